// ==== design/ioc_osc_ctrl.sv ====
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
// top: internal oscillator control with apb registers
module ioc_osc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] reset_osc_select,
  input wire logic external_osc_ready,
  output logic [2:0] active_source,
  output logic [2:0] hf_freq_out,
  output logic [3:0] divider_out,
  output logic [5:0] trim_applied,
  output logic external_osc_enable,
  output logic mf_500k_tick,
  output logic mf_32k_tick,
  output logic lf_clock_run
);
  // state of the reset strap capture
  typedef enum logic [1:0] {
    ST_STRAP = 2'b01,
    ST_RUN = 2'b10
  } ioc_phase_e;
  ioc_phase_e ph_reg, ph_next;
  // strap and external-ready synchronisers (pins from outside the domain)
  logic [2:0] rst_s1_reg, rst_s2_reg;
  logic ext_s1_reg, ext_s2_reg;
  // software registers
  logic [2:0] sel_reg, sel_next;
  logic [3:0] div_reg, div_next;
  logic [2:0] frq_reg, frq_next;
  logic [5:0] trim_reg, trim_next;
  logic [3:0] en_reg, en_next;
  logic [2:0] strap_reg, strap_next;
  // output side: glided trim, bus read data
  logic [5:0] glide_reg, glide_next;
  logic [7:0] gcnt_reg, gcnt_next;
  logic [31:0] rd_reg, rd_next;
  logic ack_reg, ack_next;
  logic err_reg, err_next;
  // mid-frequency dividers
  logic [9:0] mf_fast_reg, mf_fast_next;
  logic [10:0] mf_slow_reg, mf_slow_next;
  logic tick_f_reg, tick_f_next, tick_s_reg, tick_s_next;
  // ready flags from the oscillator models
  logic hf_rdy, mf_rdy, lf_rdy;
  logic hf_req, lf_req;
  logic [3:0] status;

  // hf request: selected as hf code or forced by software
  function automatic logic is_hf(input logic [2:0] code);
    return (code == ioc_pkg::SRC_HF_32M) || (code == ioc_pkg::SRC_HF_1M);
  endfunction : is_hf

  // apb decode of a completed access
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  assign hf_req = is_hf(sel_reg) || en_reg[ioc_pkg::BIT_HF] || en_reg[ioc_pkg::BIT_MF];
  // lf always runs: it clocks the power-up timer, watchdog and monitor
  assign lf_req = 1'b1;
  assign status = {ext_s2_reg, lf_rdy, mf_rdy, hf_rdy};

  ioc_osc_ready #(.START_CYC(ioc_pkg::START_CYC)) u_hf (
    .pclk(pclk), .presetn(presetn), .run_req(hf_req), .ready(hf_rdy));
  ioc_osc_ready #(.START_CYC(ioc_pkg::START_CYC)) u_mf (
    .pclk(pclk), .presetn(presetn), .run_req(hf_req), .ready(mf_rdy));
  ioc_osc_ready #(.START_CYC(ioc_pkg::START_CYC)) u_lf (
    .pclk(pclk), .presetn(presetn), .run_req(lf_req), .ready(lf_rdy));

  // strap synchroniser runs through reset, so the strap is settled at release
  always_ff @(posedge pclk) begin
    rst_s1_reg <= reset_osc_select;
    rst_s2_reg <= rst_s1_reg;
  end

  // synchroniser for the external ready pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
    end else begin
      ext_s1_reg <= external_osc_ready;
      ext_s2_reg <= ext_s1_reg;
    end
  end

  // control registers: strap load after release, then apb writes
  always_comb begin
    ph_next = ph_reg;
    sel_next = sel_reg;
    div_next = div_reg;
    frq_next = frq_reg;
    trim_next = trim_reg;
    en_next = en_reg;
    strap_next = strap_reg;
    unique case (ph_reg)
      ST_STRAP: begin
        // strap is caught from the synchronised pin, not under reset
        strap_next = rst_s2_reg;
        sel_next = rst_s2_reg;
        frq_next = (rst_s2_reg == ioc_pkg::SRC_HF_1M) ? ioc_pkg::FRQ_1M : ioc_pkg::FRQ_32M;
        ph_next = ST_RUN;
      end
      ST_RUN: begin
        if (psel && penable && pwrite) begin
          if (hit(paddr, ioc_pkg::OFF_CTRL)) begin
            sel_next = pwdata[ioc_pkg::CTRL_SEL_LSB +: 3];
            // divider codes above 1:512 are clamped
            div_next = (pwdata[3:0] > ioc_pkg::DIV_MAX) ? ioc_pkg::DIV_MAX
                                                       : pwdata[3:0];
          end
          if (hit(paddr, ioc_pkg::OFF_FREQ)) begin
            frq_next = pwdata[2:0];
          end
          if (hit(paddr, ioc_pkg::OFF_TRIM)) begin
            trim_next = pwdata[5:0];
          end
          if (hit(paddr, ioc_pkg::OFF_EN)) begin
            en_next = pwdata[3:0];
          end
        end
      end
    endcase
  end

  // register the control state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_reg <= ST_STRAP;
      sel_reg <= ioc_pkg::SRC_HF_32M;
      div_reg <= ioc_pkg::DIV_RST;
      frq_reg <= ioc_pkg::FRQ_RST;
      trim_reg <= ioc_pkg::TRIM_RST;
      en_reg <= 4'h0;
      strap_reg <= 3'h0;
    end else begin
      ph_reg <= ph_next;
      sel_reg <= sel_next;
      div_reg <= div_next;
      frq_reg <= frq_next;
      trim_reg <= trim_next;
      en_reg <= en_next;
      strap_reg <= strap_next;
    end
  end

  // trim glide: one signed step toward target per glide period, no done flag
  always_comb begin
    glide_next = glide_reg;
    gcnt_next = gcnt_reg + 8'h01;
    if (gcnt_reg == 8'(ioc_pkg::GLIDE_CYC - 1)) begin
      gcnt_next = 8'h00;
      if ($signed(glide_reg) < $signed(trim_reg)) begin
        glide_next = glide_reg + 6'h01;
      end else if ($signed(glide_reg) > $signed(trim_reg)) begin
        glide_next = glide_reg - 6'h01;
      end
    end
  end

  // mid-frequency tick dividers, fixed ratios untouched by trim or divider
  always_comb begin
    mf_fast_next = mf_fast_reg + 10'h001;
    mf_slow_next = mf_slow_reg + 11'h001;
    tick_f_next = 1'b0;
    tick_s_next = 1'b0;
    if (mf_fast_reg == 10'(ioc_pkg::MF_FAST_DIV - 1)) begin
      mf_fast_next = 10'h000;
      tick_f_next = mf_rdy;
    end
    if (mf_slow_reg == 11'(ioc_pkg::MF_SLOW_DIV - 1)) begin
      mf_slow_next = 11'h000;
      tick_s_next = mf_rdy;
    end
  end

  // apb read mux; unmapped addresses answer with pslverr
  always_comb begin
    rd_next = rd_reg;
    ack_next = psel && !penable;
    err_next = 1'b0;
    if (psel && !penable) begin
      rd_next = 32'h0000_0000;
      unique case (paddr)
        ioc_pkg::OFF_CTRL: rd_next[6:0] = {sel_reg, div_reg};
        ioc_pkg::OFF_FREQ: rd_next[2:0] = frq_reg;
        ioc_pkg::OFF_TRIM: rd_next[5:0] = trim_reg;
        ioc_pkg::OFF_STAT: rd_next[3:0] = status;
        ioc_pkg::OFF_EN: rd_next[3:0] = en_reg;
        ioc_pkg::OFF_RST: rd_next[2:0] = strap_reg;
        default: err_next = 1'b1;
      endcase
    end
  end

  // register glide, ticks and bus answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      glide_reg <= ioc_pkg::TRIM_RST;
      gcnt_reg <= 8'h00;
      mf_fast_reg <= 10'h000;
      mf_slow_reg <= 11'h000;
      tick_f_reg <= 1'b0;
      tick_s_reg <= 1'b0;
      rd_reg <= 32'h0000_0000;
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      glide_reg <= glide_next;
      gcnt_reg <= gcnt_next;
      mf_fast_reg <= mf_fast_next;
      mf_slow_reg <= mf_slow_next;
      tick_f_reg <= tick_f_next;
      tick_s_reg <= tick_s_next;
      rd_reg <= rd_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
    end
  end

  // outputs straight from flip-flops
  assign prdata = rd_reg;
  assign pready = ack_reg;
  assign pslverr = err_reg;
  assign active_source = sel_reg;
  assign hf_freq_out = frq_reg;
  assign divider_out = div_reg;
  assign trim_applied = glide_reg;
  assign external_osc_enable = en_reg[ioc_pkg::BIT_EXT];
  assign mf_500k_tick = tick_f_reg;
  assign mf_32k_tick = tick_s_reg;
  assign lf_clock_run = lf_rdy;

  chk_trim_step: assert property (@(posedge pclk) disable iff (!presetn)
    glide_reg != $past(glide_reg) |-> (glide_reg - $past(glide_reg) == 6'h01) ||
    ($past(glide_reg) - glide_reg == 6'h01))
    else $error("trim moved by more than one step");
  chk_trim_hold: assert property (@(posedge pclk) disable iff (!presetn)
    gcnt_reg != 8'h00 |-> glide_reg == $past(glide_reg))
    else $error("trim moved off a step slot");
  chk_trim_top: assert property (@(posedge pclk) disable iff (!presetn)
    ack_reg && !err_reg && $past(paddr) == ioc_pkg::OFF_TRIM |-> prdata[31:6] == 26'h0)
    else $error("trim upper bits not zero");
  chk_div_limit: assert property (@(posedge pclk) disable iff (!presetn)
    div_reg <= ioc_pkg::DIV_MAX)
    else $error("divider beyond 1:512");
  chk_lf_always: assert property (@(posedge pclk) disable iff (!presetn)
    lf_rdy |=> lf_rdy)
    else $error("low-frequency oscillator stopped");
  chk_hf_start: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(hf_req) |-> ##[39:41] hf_rdy)
    else $error("hf not ready after start-up");
  chk_stat_hf: assert property (@(posedge pclk) disable iff (!presetn)
    ack_reg && !err_reg && $past(paddr) == ioc_pkg::OFF_STAT && $past(hf_rdy) |-> prdata[0])
    else $error("status misses hf ready");
  chk_sel_write: assert property (@(posedge pclk) disable iff (!presetn)
    ph_reg == ST_RUN && psel && penable && pwrite && paddr == ioc_pkg::OFF_CTRL
    |=> sel_reg == $past(pwdata[6:4]))
    else $error("select write lost");
  chk_mf_gap: assert property (@(posedge pclk) disable iff (!presetn)
    tick_f_reg |=> !tick_f_reg)
    else $error("500k tick too wide");
endmodule : ioc_osc_ctrl

// ==== shared/ioc_pkg.sv ====
// package: register map, field codes and timing constants of the oscillator control block
package ioc_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_CTRL = 8'h00;   // osc_control_one
  localparam logic [7:0] OFF_FREQ = 8'h04;   // osc_frequency_register
  localparam logic [7:0] OFF_TRIM = 8'h08;   // hf_oscillator_trim
  localparam logic [7:0] OFF_STAT = 8'h0C;   // osc_ready_status
  localparam logic [7:0] OFF_EN = 8'h10;     // osc_manual_enable
  localparam logic [7:0] OFF_RST = 8'h14;    // reset_osc_select readback
  // osc_control_one fields
  localparam int CTRL_DIV_LSB = 0;           // clock_divider_select 3:0
  localparam int CTRL_SEL_LSB = 4;           // new_osc_select 6:4
  // source codes of the select fields
  localparam logic [2:0] SRC_HF_32M = 3'h1;  // high-frequency at 32 MHz
  localparam logic [2:0] SRC_EXT = 3'h2;     // external_osc
  localparam logic [2:0] SRC_LF = 3'h5;      // low_freq_internal_osc
  localparam logic [2:0] SRC_HF_1M = 3'h6;   // high-frequency at 1 MHz
  localparam logic [2:0] SRC_HF = 3'h1;      // run-time high-frequency code
  // hf_freq_select codes used at reset
  localparam logic [2:0] FRQ_1M = 3'h0;
  localparam logic [2:0] FRQ_32M = 3'h6;
  localparam logic [2:0] FRQ_RST = 3'h6;
  // reset values and the divider limit
  localparam logic [5:0] TRIM_RST = 6'h00;
  localparam logic [3:0] DIV_RST = 4'h0;
  localparam logic [3:0] DIV_MAX = 4'h9;     // 1:512
  // status/enable bit positions
  localparam int BIT_HF = 0;
  localparam int BIT_MF = 1;
  localparam int BIT_LF = 2;
  localparam int BIT_EXT = 3;
  // oscillator start-up time and glide step period
  localparam int START_NS = 1000;
  localparam int CLK_NS = 25;
  localparam int START_CYC = (START_NS + CLK_NS - 1) / CLK_NS;
  localparam int GLIDE_NS = 200;
  localparam int GLIDE_CYC = GLIDE_NS / CLK_NS;
  // mid-frequency tick periods, 500 kHz and 32 kHz, counted in pclk cycles
  localparam int MF_FAST_NS = 2000;
  localparam int MF_SLOW_NS = 31250;
  localparam int MF_FAST_DIV = MF_FAST_NS / CLK_NS;
  localparam int MF_SLOW_DIV = MF_SLOW_NS / CLK_NS;
endpackage : ioc_pkg

// ==== design/ioc_osc_ready.sv ====
`timescale 1ns/100ps
// one oscillator: request, start-up wait and ready flag
module ioc_osc_ready #(
  parameter int START_CYC = 40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run_req,
  output logic ready
);
  // elaboration check: the 16-bit counter serves 1 to 65536 cycles
  if (START_CYC < 1 || START_CYC > 65536) begin : g_bad_start
    $error("start count out of range");
  end
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic rdy_reg;
  logic rdy_next;
  // count cycles of request; ready when the wait is over, drops on the first clock edge after stop
  always_comb begin
    cnt_next = cnt_reg;
    rdy_next = rdy_reg;
    if (!run_req) begin
      cnt_next = 16'h0000;
      rdy_next = 1'b0;
    end else if (cnt_reg == 16'(START_CYC - 1)) begin
      rdy_next = 1'b1;
    end else begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end
  // registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 16'h0000;
      rdy_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      rdy_reg <= rdy_next;
    end
  end
  assign ready = rdy_reg;
endmodule : ioc_osc_ready

// ==== tb/test_ioc_osc_ctrl.sv ====
// testbench: apb register access and clock-control checks of the oscillator control block
`timescale 1ns/100ps
module test_ioc_osc_ctrl;
  logic pclk; // 40 MHz bus clock
  logic presetn; // async reset, active low
  logic psel, penable, pwrite; // apb request
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd; // rd holds the last read word
  logic pready, pslverr, er; // er holds the last error flag
  logic [2:0] reset_osc_select, active_source, hf_freq_out;
  logic external_osc_ready, external_osc_enable, mf_500k_tick, mf_32k_tick, lf_clock_run;
  logic [3:0] divider_out;
  logic [5:0] trim_applied;
  logic counting; // opens the tick-counting window
  int miscompares, checked, cycles, n_fast, n_slow;
  localparam int LIMIT = 20000; // whole run needs about 4800 cycles

  ioc_osc_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reset_osc_select(reset_osc_select),
    .external_osc_ready(external_osc_ready), .active_source(active_source),
    .hf_freq_out(hf_freq_out), .divider_out(divider_out), .trim_applied(trim_applied),
    .external_osc_enable(external_osc_enable), .mf_500k_tick(mf_500k_tick),
    .mf_32k_tick(mf_32k_tick), .lf_clock_run(lf_clock_run));

  // clock: 25 ns period
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // verdict and end of run, the one place that finishes
  task automatic close_out;
    $display("checks %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // hang guard and tick counters; values seen here are those sampled at the edge
  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (counting) begin
      n_fast = n_fast + int'(mf_500k_tick);
      n_slow = n_slow + int'(mf_32k_tick);
    end
    if (cycles == LIMIT) begin
      miscompares = miscompares + 1;
      close_out();
    end
  end

  // one comparison; case inequality so an unknown never matches
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked = checked + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // one apb transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no timeout here: if pready never comes, only the bench's cycle limit ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    chk("pready", 32'h1, 32'(pready));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // write, then let the registered outputs settle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
    repeat (8) @(posedge pclk);
  endtask : wr

  // reset with a given strap; strap is stable long before release
  task automatic do_reset(input logic [2:0] strap);
    reset_osc_select <= strap;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (60) @(posedge pclk);
  endtask : do_reset

  // main sequence
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    presetn = 1'b0; reset_osc_select = ioc_pkg::SRC_HF_1M; external_osc_ready = 1'b0;
    counting = 1'b0; miscompares = 0; checked = 0; cycles = 0; n_fast = 0; n_slow = 0;
    do_reset(ioc_pkg::SRC_HF_1M);
    chk("active_source", 32'(ioc_pkg::SRC_HF_1M), 32'(active_source));
    chk("hf_freq_out", 32'(ioc_pkg::FRQ_1M), 32'(hf_freq_out));
    apb(ioc_pkg::OFF_RST, 1'b0, 32'h0);
    chk("strap", 32'h6, rd);
    apb(ioc_pkg::OFF_TRIM, 1'b0, 32'h0);
    chk("trim", 32'h0, rd);
    chk("trim_applied", 32'h0, 32'(trim_applied));
    // run-time source switch; the wait covers the start-up of the target
    wr(ioc_pkg::OFF_CTRL, 32'({ioc_pkg::SRC_LF, 4'h0}));
    repeat (50) @(posedge pclk);
    chk("active_source", 32'(ioc_pkg::SRC_LF), 32'(active_source));
    // every divider code; codes above 1:512 clamp
    for (int i = 0; i < 16; i++) begin
      wr(ioc_pkg::OFF_CTRL, 32'({ioc_pkg::SRC_HF, 4'(i)}));
      chk("divider_out", (i > 9) ? 32'h9 : 32'(i), 32'(divider_out));
    end
    repeat (50) @(posedge pclk);
    chk("active_source", 32'(ioc_pkg::SRC_HF), 32'(active_source));
    apb(ioc_pkg::OFF_CTRL, 1'b0, 32'h0);
    chk("ctrl", 32'({ioc_pkg::SRC_HF, ioc_pkg::DIV_MAX}), rd);
    // every frequency code at the port, the last one on readback
    for (int i = 0; i < 8; i++) begin
      wr(ioc_pkg::OFF_FREQ, 32'(i));
      chk("hf_freq_out", 32'(i), 32'(hf_freq_out));
    end
    apb(ioc_pkg::OFF_FREQ, 1'b0, 32'h0);
    chk("freq", 32'h7, rd);
    // trim: upper bits drop, value glides with no done flag
    wr(ioc_pkg::OFF_TRIM, 32'hFFFF_FFDF);
    chk("trim_moving", 32'h1, 32'(trim_applied < 6'h1F));
    apb(ioc_pkg::OFF_TRIM, 1'b0, 32'h0);
    chk("trim", 32'h1F, rd);
    repeat (300) @(posedge pclk);
    chk("trim_applied", 32'h1F, 32'(trim_applied));
    wr(ioc_pkg::OFF_TRIM, 32'h20);
    repeat (600) @(posedge pclk);
    chk("trim_applied", 32'h20, 32'(trim_applied));
    chk("lf_clock_run", 32'h1, 32'(lf_clock_run));
    // status is read-only; manual enable drives the external request
    wr(ioc_pkg::OFF_STAT, 32'h0);
    apb(ioc_pkg::OFF_STAT, 1'b0, 32'h0);
    chk("status", 32'h5, rd & 32'h5);
    chk("pslverr", 32'h0, 32'(er));
    external_osc_ready <= 1'b1;
    wr(ioc_pkg::OFF_EN, 32'h8);
    chk("external_osc_enable", 32'h1, 32'(external_osc_enable));
    apb(ioc_pkg::OFF_STAT, 1'b0, 32'h0);
    chk("status_ext", 32'h8, rd & 32'h8);
    wr(ioc_pkg::OFF_EN, 32'h0);
    chk("external_osc_enable", 32'h0, 32'(external_osc_enable));
    // unmapped address is refused both ways
    apb(8'h18, 1'b1, 32'h7);
    chk("pslverr", 32'h1, 32'(er));
    apb(8'h18, 1'b0, 32'h0);
    chk("pslverr", 32'h1, 32'(er));
    // mid-frequency ticks over a window of 3200 cycles
    @(posedge pclk);
    counting <= 1'b1;
    repeat (3200) @(posedge pclk);
    counting <= 1'b0;
    @(posedge pclk);
    // 3200 cycles are 80 us: 40 ticks at 500 kHz, 2 or 3 at 32 kHz
    chk("fast_ticks", 32'd40, 32'(n_fast));
    chk("slow_ticks", 32'h1, 32'(n_slow >= 2 && n_slow <= 3));
    // strap-selected sources at a later reset
    do_reset(ioc_pkg::SRC_LF);
    chk("active_source", 32'(ioc_pkg::SRC_LF), 32'(active_source));
    do_reset(ioc_pkg::SRC_HF_32M);
    chk("active_source", 32'(ioc_pkg::SRC_HF_32M), 32'(active_source));
    chk("hf_freq_out", 32'(ioc_pkg::FRQ_32M), 32'(hf_freq_out));
    close_out();
  end
endmodule : test_ioc_osc_ctrl
